// *** rtl/lpb_defs.svh ***
// Register offsets, reset values and timing counts of the LED intensity and blink block.
`ifndef LPB_DEFS_SVH
`define LPB_DEFS_SVH

`define LPB_ADDR_PHASE0_LO      8'h02
`define LPB_ADDR_PHASE0_HI      8'h03
`define LPB_ADDR_PHASE1_LO      8'h0A
`define LPB_ADDR_PHASE1_HI      8'h0B
`define LPB_ADDR_MASTER         8'h0E
`define LPB_ADDR_INTENSITY_BASE 8'h10
`define LPB_ADDR_INTENSITY_LAST 8'h17

`define LPB_MASTER_FIELD_MSB    7
`define LPB_MASTER_FIELD_LSB    4
`define LPB_DUTY_FIELD_MSB      3
`define LPB_DUTY_FIELD_LSB      0
`define LPB_DUTY_STATIC         4'h0F

`define LPB_RST_PHASE           16'hFFFF
`define LPB_RST_MASTER          8'h00
`define LPB_RST_INTENSITY       8'h00
`define LPB_RST_READ            8'h00

`define LPB_CLK_HZ              20000000
`define LPB_OSC_HZ              32000
`define LPB_TICK_CYCLES         (`LPB_CLK_HZ / `LPB_OSC_HZ)
`define LPB_SLOTS_PER_PERIOD    4'h0F
`define LPB_CYCLES_PER_SLOT     5'h10

`endif

// *** rtl/lpb_pkg.sv ***
// Types shared by the LED intensity and blink block.
package lpb_pkg;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lpb_reg_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } lpb_reg_rsp_s;

    typedef struct packed {
        logic             global_en;
        logic             blink_en;
        logic             blink_flip;
        logic             extra_phase0;
        logic             extra_phase1;
    } lpb_cfg_s;

    typedef struct packed {
        logic [15:0]      phase0;
        logic [15:0]      phase1;
        logic [7:0]       master;
        logic [7:0][7:0]  intensity;
        logic [9:0]       tick_cnt;
        logic [3:0]       slot;
        logic [3:0]       cyc;
        logic             blink_meta;
        logic             blink_sync;
        lpb_reg_rsp_s     rsp;
        logic [16:0]      pin_oe;
    } lpb_state_s;

endpackage

// *** rtl/lpb_pwm.sv ***
// Register bank, 240-step intensity timing and blink selection for 17 open-drain outputs.
`timescale 1ns/1ps
`include "lpb_defs.svh"

module lpb_pwm #(
    parameter int TICK_CYCLES = `LPB_TICK_CYCLES
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire lpb_pkg::lpb_reg_req_s req,
    output lpb_pkg::lpb_reg_rsp_s  rsp,
    input  wire lpb_pkg::lpb_cfg_s cfg,
    input  wire logic              blink_pin,
    output logic [15:0]            port_pin_out,
    output logic [15:0]            port_pin_oe,
    output logic                   extra_output_out,
    output logic                   extra_output_oe
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Parameter checks.

    // The step counter is ten bits wide, so a longer tick cannot be counted.
    if (TICK_CYCLES < 1 || TICK_CYCLES > 1024)
    begin : gen_bad_tick
        $error("TICK_CYCLES must lie between 1 and 1024.");
    end

    localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);

    lpb_pkg::lpb_state_s state;
    lpb_pkg::lpb_state_s next_state;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Intensity decode.

    logic [3:0]  master_field;
    logic [3:0]  extra_duty;
    logic        modulation_on;
    logic        active_phase;
    logic        slot_gated;
    logic [16:0] next_level;
    logic        step_tick;

    assign master_field  = state.master[`LPB_MASTER_FIELD_MSB:`LPB_MASTER_FIELD_LSB];
    assign extra_duty    = state.master[`LPB_DUTY_FIELD_MSB:`LPB_DUTY_FIELD_LSB];
    // A zero master field stops all modulation and makes every output static.
    assign modulation_on = (master_field != 4'h0);
    // The pin is only read after the second synchroniser stage.
    assign active_phase  = cfg.blink_en & (cfg.blink_flip ^ state.blink_sync);
    assign slot_gated    = (state.slot < master_field);
    assign step_tick     = modulation_on && (state.tick_cnt == TICK_LAST);

    genvar g;
    generate
        for (g = 0; g < 17; g++)
        begin : gen_out
            logic [3:0] own_duty;
            logic [3:0] duty;
            logic       bit0;
            logic       bit1;
            logic       level_bit;
            logic       on_time;

            if (g < 16)
            begin : gen_port
                // Even outputs sit in the low nibble, odd outputs in the high nibble.
                assign own_duty = state.intensity[g / 2][(g % 2) * 4 +: 4];
                assign bit0     = state.phase0[g];
                assign bit1     = state.phase1[g];
            end
            else
            begin : gen_extra
                assign own_duty = extra_duty;
                assign bit0     = cfg.extra_phase0;
                assign bit1     = cfg.extra_phase1;
            end

            // Global control swaps in the shared nibble for every output.
            assign duty      = cfg.global_en ? extra_duty : own_duty;
            assign level_bit = active_phase ? bit1 : bit0;
            // On-time covers cycles 0..duty, so setting n gives n+1 sixteenths.
            assign on_time   = slot_gated && (state.cyc <= duty);

            always_comb
            begin
                if (!modulation_on || duty == `LPB_DUTY_STATIC)
                begin
                    next_level[g] = level_bit;
                end
                else
                begin
                    // Outside the on-time the output shows the inverse level.
                    next_level[g] = on_time ? level_bit : ~level_bit;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb
    begin
        next_state = state;

        // The pin is asynchronous, so it passes two flip-flops first.
        next_state.blink_meta = blink_pin;
        next_state.blink_sync = state.blink_meta;

        // Timing counters are frozen at zero while modulation is off, like a stopped
        // oscillator; a nonzero master value written while the field is zero therefore starts at slot 0.
        if (!modulation_on)
        begin
            next_state.tick_cnt = 10'h000;
            next_state.slot     = 4'h0;
            next_state.cyc      = 4'h0;
        end
        else if (step_tick)
        begin
            next_state.tick_cnt = 10'h000;
            if (state.cyc == 4'(`LPB_CYCLES_PER_SLOT - 5'h01))
            begin
                next_state.cyc = 4'h0;
                if (state.slot == `LPB_SLOTS_PER_PERIOD - 4'h1)
                begin
                    next_state.slot = 4'h0;
                end
                else
                begin
                    next_state.slot = state.slot + 4'h1;
                end
            end
            else
            begin
                next_state.cyc = state.cyc + 4'h1;
            end
        end
        else
        begin
            next_state.tick_cnt = state.tick_cnt + 10'h001;
        end

        // Register writes; unmapped addresses are ignored.
        if (req.valid && req.write)
        begin
            unique case (req.addr)
                `LPB_ADDR_PHASE0_LO: next_state.phase0[7:0]  = req.wdata;
                `LPB_ADDR_PHASE0_HI: next_state.phase0[15:8] = req.wdata;
                `LPB_ADDR_PHASE1_LO: next_state.phase1[7:0]  = req.wdata;
                `LPB_ADDR_PHASE1_HI: next_state.phase1[15:8] = req.wdata;
                `LPB_ADDR_MASTER:    next_state.master       = req.wdata;
                default:
                begin
                    if (req.addr >= `LPB_ADDR_INTENSITY_BASE &&
                        req.addr <= `LPB_ADDR_INTENSITY_LAST)
                    begin
                        next_state.intensity[req.addr[2:0]] = req.wdata;
                    end
                end
            endcase
        end

        // Reads answer one cycle later; unmapped addresses read as zero.
        next_state.rsp.valid = req.valid && !req.write;
        next_state.rsp.rdata = `LPB_RST_READ;
        if (req.valid && !req.write)
        begin
            unique case (req.addr)
                `LPB_ADDR_PHASE0_LO: next_state.rsp.rdata = state.phase0[7:0];
                `LPB_ADDR_PHASE0_HI: next_state.rsp.rdata = state.phase0[15:8];
                `LPB_ADDR_PHASE1_LO: next_state.rsp.rdata = state.phase1[7:0];
                `LPB_ADDR_PHASE1_HI: next_state.rsp.rdata = state.phase1[15:8];
                `LPB_ADDR_MASTER:    next_state.rsp.rdata = state.master;
                default:
                begin
                    if (req.addr >= `LPB_ADDR_INTENSITY_BASE &&
                        req.addr <= `LPB_ADDR_INTENSITY_LAST)
                    begin
                        next_state.rsp.rdata = state.intensity[req.addr[2:0]];
                    end
                end
            endcase
        end

        // Open drain: a high level releases the pin, a low level sinks current.
        next_state.pin_oe = ~next_level;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state.phase0     <= `LPB_RST_PHASE;
            state.phase1     <= `LPB_RST_PHASE;
            state.master     <= `LPB_RST_MASTER;
            state.intensity  <= {8{`LPB_RST_INTENSITY}};
            state.tick_cnt   <= 10'h000;
            state.slot       <= 4'h0;
            state.cyc        <= 4'h0;
            state.blink_meta <= 1'b0;
            state.blink_sync <= 1'b0;
            state.rsp        <= '0;
            state.pin_oe     <= 17'h0_0000;
        end
        else if (ce)
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign rsp                  = state.rsp;
    assign port_pin_out         = 16'h0000;
    assign port_pin_oe          = state.pin_oe[15:0];
    assign extra_output_out     = 1'b0;
    assign extra_output_oe      = state.pin_oe[16];

endmodule

// *** sim/lpb_od_load.sv ***
// Pull-up loads on the open-drain outputs.
`timescale 1ns/1ps
module lpb_od_load (
    input  wire logic [15:0] port_pin_oe,
    input  wire logic        extra_output_oe,
    output logic      [15:0] port_level,
    output logic             extra_level
);
    // A released pin rises through its pull-up; the load never drives a level of its own.
    assign port_level  = ~port_pin_oe;
    assign extra_level = ~extra_output_oe;
endmodule

// *** sim/lpb_pwm_sva.sv ***
// Port assertions for the intensity and blink block.
`timescale 1ns/1ps
module lpb_pwm_sva #(
    parameter int TICK_CYCLES = 625
)
(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire lpb_pkg::lpb_reg_req_s req,
    input wire lpb_pkg::lpb_reg_rsp_s rsp,
    input wire lpb_pkg::lpb_cfg_s     cfg,
    input wire logic                  blink_pin,
    input wire logic [15:0]           port_pin_out,
    input wire logic [15:0]           port_pin_oe,
    input wire logic                  extra_output_out,
    input wire logic                  extra_output_oe
);
    logic [7:0] m_shadow;
    logic       rd_take;
    logic       wr_take;
    logic       is_static;
    assign rd_take   = ce && req.valid && !req.write;
    assign wr_take   = ce && req.valid && req.write;
    assign is_static = (m_shadow[7:4] == 4'h0) || (cfg.global_en && m_shadow[3:0] == 4'hF);
    // The master value is mirrored so that readback and static mode can be judged here.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            m_shadow <= 8'h00;
        else if (wr_take && req.addr == 8'h0E)
            m_shadow <= req.wdata;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_quiet;
        is_static && !req.valid && $stable(cfg) && $stable(blink_pin);
    endsequence
    property p_od; port_pin_out == 16'h0000 && extra_output_out == 1'b0; endproperty
    property p_rd; rd_take |=> rsp.valid; endproperty
    property p_wr; wr_take |=> !rsp.valid; endproperty
    property p_once; rsp.valid && ce && !rd_take |=> !rsp.valid; endproperty
    property p_unmap; rd_take && req.addr == 8'h20 |=> rsp.rdata == 8'h00; endproperty
    property p_mrd; rd_take && req.addr == 8'h0E |=> rsp.rdata == m_shadow; endproperty
    property p_static; s_quiet [*3] |=> $stable(port_pin_oe) && $stable(extra_output_oe);
    endproperty
    property p_ce; !ce |=> $stable(port_pin_oe) && $stable(rsp); endproperty
    a_od: assert property (p_od) else $error("open-drain data not low");
    a_rd: assert property (p_rd) else $error("read not answered");
    a_wr: assert property (p_wr) else $error("write answered");
    a_once: assert property (p_once) else $error("response held too long");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_mrd: assert property (p_mrd) else $error("master readback wrong");
    a_static: assert property (p_static) else $error("static output moved");
    a_ce: assert property (p_ce) else $error("state moved with enable low");
    c_rd: cover property (rd_take && req.addr == 8'h0A);
    c_glob: cover property (cfg.global_en && !is_static);
    c_blink: cover property (cfg.blink_en && $rose(blink_pin));
endmodule

bind lpb_pwm lpb_pwm_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.clk_sys, .rst, .ce, .req, .rsp,
    .cfg, .blink_pin, .port_pin_out, .port_pin_oe, .extra_output_out, .extra_output_oe);

// *** sim/tb.sv ***
// Self-checking bench for the intensity and blink block.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    compares++; \
    if ((got) !== (exp)) \
    begin \
        mismatches++; \
        $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
    end
module tb;
    localparam int T = 2;
    // Rows are {global, gate, duty}; the short tick keeps a period at 480 cycles.
    localparam logic [8:0] ROWS [5] = '{9'h010, 9'h0FE, 9'h037, 9'h124, 9'h15F};
    logic                  clk_sys;
    logic                  rst;
    logic                  ce;
    lpb_pkg::lpb_reg_req_s req;
    lpb_pkg::lpb_reg_rsp_s rsp;
    lpb_pkg::lpb_cfg_s     cfg;
    logic                  blink_pin;
    logic [15:0]           port_pin_out;
    logic [15:0]           port_pin_oe;
    logic                  extra_output_out;
    logic                  extra_output_oe;
    logic [15:0]           port_level;
    logic                  extra_level;
    int                    mismatches;
    int                    compares;
    lpb_pwm #(.TICK_CYCLES(T)) dut (.clk_sys, .rst, .ce, .req, .rsp, .cfg, .blink_pin,
        .port_pin_out, .port_pin_oe, .extra_output_out, .extra_output_oe);
    lpb_od_load u_load (.port_pin_oe, .extra_output_oe, .port_level, .extra_level);
    ////////////////////////////////////////
    task automatic go(input int n);
        req.valid = 1'b0;
        repeat (n) @(posedge clk_sys) #1;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        req = '{valid: 1'b1, write: w, addr: a, wdata: d};
        @(posedge clk_sys) #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        `CHK("rsp_valid", 1'b1, rsp.valid)
        `CHK("rdata", exp, rsp.rdata)
    endtask
    task automatic regs_check;
        rd(8'h0A, 8'hFF);
        acc(1'b1, 8'h0A, 8'h5A);
        acc(1'b1, 8'h0B, 8'hA5);
        acc(1'b1, 8'h11, 8'h3C);
        rd(8'h0A, 8'h5A);
        rd(8'h0B, 8'hA5);
        rd(8'h11, 8'h3C);
        rd(8'h20, 8'h00);
        go(1);
    endtask
    task automatic static_check;
        int i;
        acc(1'b1, 8'h02, 8'hF0);
        acc(1'b1, 8'h03, 8'h0F);
        acc(1'b1, 8'h10, 8'h00);
        acc(1'b1, 8'h0E, 8'h0A);
        rd(8'h0E, 8'h0A);
        cfg.global_en = 1'b1;
        go(3);
        for (i = 0; i < 40; i++)
        begin
            `CHK("static_oe", 16'hF00F, port_pin_oe)
            `CHK("static_lvl", 16'h0FF0, port_level)
            `CHK("static_x", 1'b1, extra_output_oe)
            `CHK("static_xlvl", 1'b0, extra_level)
            go(7);
        end
    endtask
    task automatic pwm_check;
        int r, e, c0, c1, c2, cx;
        acc(1'b1, 8'h02, 8'hFA);
        for (r = 0; r < 5; r++)
        begin
            cfg.global_en = ROWS[r][8];
            acc(1'b1, 8'h10, ROWS[r][8] ? 8'h77 : {2{ROWS[r][3:0]}});
            acc(1'b1, 8'h11, 8'h0F);
            acc(1'b1, 8'h0E, ROWS[r][7:0]);
            go(8);
            e = (ROWS[r][3:0] == 4'hF) ? 240 * T
                : int'(ROWS[r][7:4]) * (int'(ROWS[r][3:0]) + 1) * T;
            c0 = 0;
            c1 = 0;
            c2 = 0;
            cx = 0;
            repeat (240 * T)
            begin
                c0 += int'(port_pin_oe[0]);
                c1 += int'(port_pin_oe[1]);
                c2 += int'(port_pin_oe[2]);
                cx += int'(extra_output_oe);
                @(posedge clk_sys) #1;
            end
            `CHK("on_bit0", e, c0)
            `CHK("on_bit1", 240 * T - e, c1)
            `CHK("on_bit2", ROWS[r][8] ? e : 240 * T, c2)
            `CHK("on_extra", e, cx)
        end
    endtask
    task automatic blink_check;
        int i;
        acc(1'b1, 8'h0E, 8'h00);
        acc(1'b1, 8'h02, 8'h00);
        acc(1'b1, 8'h0A, 8'hFF);
        cfg.global_en = 1'b0;
        cfg.extra_phase1 = 1'b1;
        for (i = 0; i < 5; i++)
        begin
            cfg.blink_en = (i < 4);
            cfg.blink_flip = i[0] ^ (i == 4);
            blink_pin = i[1];
            go(5);
            `CHK("blink_oe", (i < 4) ? !(i[0] ^ i[1]) : 1'b1, port_pin_oe[0])
            `CHK("blink_x", (i < 4) ? !(i[0] ^ i[1]) : 1'b1, extra_output_oe)
        end
        ce = 1'b0;
        go(4);
        ce = 1'b1;
        rd(8'h0A, 8'hFF);
    endtask
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        mismatches = 0;
        compares = 0;
        rst = 1'b1;
        ce = 1'b1;
        blink_pin = 1'b0;
        req = '0;
        cfg = '0;
        repeat (10) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        regs_check();
        static_check();
        pwm_check();
        blink_check();
        conclude();
    end
    // A hang is cut short well beyond the few thousand cycles the run needs.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        conclude();
    end
endmodule
